// ==== src/smbra_pkg.sv ====
// shared constants for the serial management bus register access link
`default_nettype none
package smbra_pkg;
  // ==========================================================
  // bus address and framing
  localparam logic [6:0] SMBRA_DEV_ADDR   = 7'h2e;
  localparam logic [3:0] SMBRA_BYTE_BITS  = 4'h8;
  localparam logic [3:0] SMBRA_ACK_SLOT   = 4'h8;
  // ==========================================================
  // timing
  localparam int         SMBRA_CLK_MHZ    = 250;
  localparam int         SMBRA_TIMEOUT_MS = 35;
  localparam int         SMBRA_TIMEOUT_CYC =
    SMBRA_TIMEOUT_MS * 1000 * SMBRA_CLK_MHZ;
  localparam logic [7:0] SMBRA_HALF_DIV   = 8'h08;
  // ==========================================================
  // master command codes
  typedef enum logic [1:0] {
    SMBRA_CMD_SEND    = 2'b00,
    SMBRA_CMD_WRITE   = 2'b01,
    SMBRA_CMD_RECV    = 2'b10,
    SMBRA_CMD_RDBYTE  = 2'b11
  } smbra_cmd_t;
endpackage
`default_nettype wire

// ==== src/smbra_if.sv ====
// open-drain two-wire link between the bus master and the slave
`default_nettype none
interface smbra_if;
  logic clk_o;
  logic clk_oe;
  logic dat_m_o;
  logic dat_m_oe;
  logic dat_s_o;
  logic dat_s_oe;
  // ==========================================================
  // wired-and with pull-up
  wire  bus_clk = ~(clk_oe & ~clk_o);
  wire  bus_dat = ~(dat_m_oe & ~dat_m_o) & ~(dat_s_oe & ~dat_s_o);
  modport master (output clk_o, output clk_oe, output dat_m_o,
                  output dat_m_oe, input bus_clk, input bus_dat);
  modport slave  (output dat_s_o, output dat_s_oe,
                  input bus_clk, input bus_dat);
endinterface
`default_nettype wire

// ==== src/smbra_slave.sv ====
// slave end: address match, pointer register, register read and write
// ==========================================================
// What this block does
// R1 - answer only seven-bit address 0x2e
// R2 - master sends address byte with direction bit
// R3 - nine clocks per byte, msb first, ack
// R4 - data changes only while clock low, except the timeout release, which can happen with clock high
// R5 - master ends write with stop
// R6 - master ends read with nack, stop
// R7 - address byte fixes direction per operation
// R8 - writes one or two bytes, reads one
// R9 - first write byte loads pointer
// R10 - second write byte stored at pointer
// R11 - read returns register at current pointer
// R12 - send byte: acknowledge both, load pointer
// R13 - write byte: acknowledge all three bytes
// R14 - repeated start read after pointer write
// R15 - repeated start begins new operation
// R16 - read byte transaction supported
// R17 - read address drives pointed register byte
// R18 - master nacks receive byte then stops
// R19 - release bus after 35 ms idle
// R20 - ignore transaction with foreign address
`default_nettype none
module smbra_slave
  import smbra_pkg::*;
#(
  parameter int TIMEOUT_CYC = SMBRA_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link
  smbra_if.slave           bus,
  // configuration
  input  wire logic        timeout_dis,
  // register file side
  output logic [7:0]       pointer,
  output logic             reg_wr,
  output logic [7:0]       reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  typedef enum logic [2:0] {
    SMBRA_S_IDLE = 3'b000,
    SMBRA_S_ADDR = 3'b001,
    SMBRA_S_PTR  = 3'b010,
    SMBRA_S_DATA = 3'b011,
    SMBRA_S_READ = 3'b100,
    SMBRA_S_SKIP = 3'b101
  } smbra_sst_t;

  // ==========================================================
  // pin synchronisers
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic       scl_d;
  logic       sda_d;
  always_ff @(posedge clk) begin
    scl_sy <= {scl_sy[0], bus.bus_clk};
    sda_sy <= {sda_sy[0], bus.bus_dat};
    scl_d  <= scl_sy[1];
    sda_d  <= sda_sy[1];
  end
  wire scl      = scl_sy[1];
  wire sda      = sda_sy[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // R4 start and stop detect
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;

  // ==========================================================
  // state
  smbra_sst_t  st;
  logic [3:0]  bitn;
  logic [7:0]  shreg;
  logic        drive_low;
  logic        ack_phase;
  logic        nacked;
  logic [31:0] idle_cnt;
  logic        addr_hit_q;
  logic        dir_rd_q;

  wire last_bit  = bitn == SMBRA_BYTE_BITS - 4'h1;
  wire in_ack    = bitn == SMBRA_ACK_SLOT;
  wire [7:0] rx_byte = {shreg[6:0], sda};
  // R1 fixed address compare
  wire addr_hit  = rx_byte[7:1] == SMBRA_DEV_ADDR;
  // R19 idle timeout
  wire timed_out = ~timeout_dis &&
                   idle_cnt >= 32'(TIMEOUT_CYC);

  always_ff @(posedge clk) begin
    if (!reset_n || timed_out) begin
      st        <= SMBRA_S_IDLE;
      bitn      <= 4'h0;
      shreg     <= 8'h00;
      drive_low <= 1'b0;
      ack_phase <= 1'b0;
      nacked    <= 1'b0;
      reg_wr    <= 1'b0;
      reg_wdata <= 8'h00;
      idle_cnt  <= 32'h0;
      if (!reset_n) begin
        pointer <= 8'h00;
      end
    end else begin
      reg_wr <= 1'b0;
      if (scl_rise || scl_fall || st == SMBRA_S_IDLE) begin
        idle_cnt <= 32'h0;
      end else begin
        idle_cnt <= idle_cnt + 32'h1;
      end
      // R15 repeated start begins new operation
      if (start_c) begin
        st        <= SMBRA_S_ADDR;
        bitn      <= 4'h0;
        drive_low <= 1'b0;
        ack_phase <= 1'b0;
      end else if (stop_c) begin
        st        <= SMBRA_S_IDLE;
        drive_low <= 1'b0;
      end else if (st != SMBRA_S_IDLE && st != SMBRA_S_SKIP) begin
        // R3 sample data on clock rise
        if (scl_rise && !in_ack) begin
          shreg <= rx_byte;
          bitn  <= bitn + 4'h1;
        end else if (scl_rise && in_ack) begin
          nacked <= sda;
        end
        // R4 change data only after clock falls
        if (scl_fall) begin
          if (st == SMBRA_S_READ) begin
            if (ack_phase) begin
              // R6 master nack ends the read
              ack_phase <= 1'b0;
              drive_low <= 1'b0;
              st        <= nacked ? SMBRA_S_SKIP : SMBRA_S_READ;
              bitn      <= 4'h0;
            end else if (bitn == SMBRA_BYTE_BITS) begin
              ack_phase <= 1'b1;
              drive_low <= 1'b0;
            end else begin
              // R17 shift out pointed register
              // rises shift the register too, so bit 7 is always next
              drive_low <= ~shreg[7];
            end
          end else if (in_ack && !ack_phase) begin
            ack_phase <= 1'b1;
            unique case (st)
              SMBRA_S_ADDR: begin
                // R20 stay released on foreign address
                if (!addr_hit_q) begin
                  st <= SMBRA_S_SKIP;
                end else begin
                  drive_low <= 1'b1;
                end
              end
              // R12 R13 acknowledge command and data bytes
              default: drive_low <= 1'b1;
            endcase
          end else if (ack_phase) begin
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
            bitn      <= 4'h0;
            unique case (st)
              SMBRA_S_ADDR: begin
                // R7 direction fixed by address byte
                if (dir_rd_q) begin
                  st        <= SMBRA_S_READ;
                  // R11 read at current pointer
                  shreg     <= reg_rdata;
                  drive_low <= ~reg_rdata[7];
                end else begin
                  st <= SMBRA_S_PTR;
                end
              end
              SMBRA_S_PTR: begin
                // R9 first byte loads pointer
                pointer <= shreg;
                st      <= SMBRA_S_DATA;
              end
              SMBRA_S_DATA: begin
                // R10 second byte into pointed register
                reg_wr    <= 1'b1;
                reg_wdata <= shreg;
                // R8 further bytes are ignored
                st        <= SMBRA_S_SKIP;
              end
              default: st <= SMBRA_S_SKIP;
            endcase
          end
        end
      end
    end
  end

  // address byte results latched at eighth bit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_hit_q <= 1'b0;
      dir_rd_q   <= 1'b0;
    end else if (st == SMBRA_S_ADDR && scl_rise && last_bit) begin
      addr_hit_q <= addr_hit;
      dir_rd_q   <= sda;
    end
  end

  // ==========================================================
  // open-drain pin, low only when acknowledging or sending zero
  logic sda_oe;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= drive_low && !timed_out;
    end
  end
  assign bus.dat_s_o  = 1'b0;
  assign bus.dat_s_oe = sda_oe;
endmodule
`default_nettype wire

// ==== src/smbra_master.sv ====
// master end: issues send, write, receive and read byte transactions
`default_nettype none
module smbra_master
  import smbra_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link
  smbra_if.master          bus,
  // user request
  input  wire logic        req,
  input  wire smbra_cmd_t  cmd,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  wdata,
  // user answer
  output logic             busy,
  output logic             done,
  output logic             ack_err,
  output logic [7:0]       rdata
);
  typedef enum logic [2:0] {
    SMBRA_M_IDLE  = 3'b000,
    SMBRA_M_START = 3'b001,
    SMBRA_M_BYTE  = 3'b010,
    SMBRA_M_STOP  = 3'b011,
    SMBRA_M_DONE  = 3'b100
  } smbra_mst_t;

  // ==========================================================
  // quarter-period tick from clock divider
  logic [7:0] div;
  wire        tick = div == SMBRA_HALF_DIV - 8'h01;
  always_ff @(posedge clk) begin
    if (!reset_n || tick) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  logic [1:0] sda_sy;
  always_ff @(posedge clk) begin
    sda_sy <= {sda_sy[0], bus.bus_dat};
  end

  smbra_mst_t st;
  smbra_cmd_t cmd_q;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [1:0] byte_n;
  logic [7:0] tx;
  logic       scl_q;
  logic       sda_q;
  logic       rs_pending;

  // R2 address byte with direction bit
  wire [7:0] addr_w = {SMBRA_DEV_ADDR, 1'b0};
  wire [7:0] addr_r = {SMBRA_DEV_ADDR, 1'b1};
  wire reading = (cmd_q == SMBRA_CMD_RECV) ||
                 (cmd_q == SMBRA_CMD_RDBYTE && rs_pending);
  // R12 R13 send byte ends after two bytes, write byte after three
  wire [1:0] last_byte = (cmd_q == SMBRA_CMD_WRITE) ? 2'h2 :
                         reading ? 2'h1 : 2'h1;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= SMBRA_M_IDLE; cmd_q <= SMBRA_CMD_SEND; ph <= 2'h0;
      bitn <= 4'h0; byte_n <= 2'h0; tx <= 8'h00; scl_q <= 1'b1;
      sda_q <= 1'b1; rs_pending <= 1'b0; busy <= 1'b0;
      done <= 1'b0; ack_err <= 1'b0; rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      unique case (st)
        SMBRA_M_IDLE: if (req) begin
          cmd_q <= cmd; busy <= 1'b1; ack_err <= 1'b0;
          rs_pending <= 1'b0; st <= SMBRA_M_START; ph <= 2'h0;
          tx <= (cmd == SMBRA_CMD_RECV) ? addr_r : addr_w;
        end
        SMBRA_M_START: if (tick) begin
          ph <= ph + 2'h1;
          unique case (ph)
            2'h0: begin sda_q <= 1'b1; end
            2'h1: begin scl_q <= 1'b1; end
            2'h2: begin sda_q <= 1'b0; end
            2'h3: begin
              scl_q <= 1'b0; st <= SMBRA_M_BYTE;
              bitn <= 4'h0; byte_n <= 2'h0;
            end
          endcase
        end
        // R3 nine clocks per byte
        SMBRA_M_BYTE: if (tick) begin
          ph <= ph + 2'h1;
          unique case (ph)
            // R4 data set while clock low
            2'h0: sda_q <= (bitn == SMBRA_ACK_SLOT) ?
                     !(reading && byte_n != 2'h0 && byte_n != last_byte)
                   : (reading && byte_n != 2'h0) ? 1'b1
                   : tx[7 - bitn[2:0]];
            2'h1: scl_q <= 1'b1;
            2'h2: if (bitn == SMBRA_ACK_SLOT) begin
                if (!(reading && byte_n != 2'h0) && sda_sy[1])
                  ack_err <= 1'b1;
              end else begin
                rdata <= {rdata[6:0], sda_sy[1]};
              end
            2'h3: begin
              scl_q <= 1'b0;
              if (bitn != SMBRA_ACK_SLOT) begin
                bitn <= bitn + 4'h1;
              end else begin
                bitn <= 4'h0; byte_n <= byte_n + 2'h1;
                if (byte_n == 2'h0) tx <= cmd_code;
                else tx <= wdata;
                if (ack_err || byte_n == last_byte) begin
                  st <= SMBRA_M_STOP;
                  // R14 R16 repeated start straight after the final ack
                  // avoids moving data and clock in the same cycle
                  if (cmd_q == SMBRA_CMD_RDBYTE && !rs_pending &&
                      !ack_err) begin
                    rs_pending <= 1'b1;
                    tx         <= addr_r;
                    st         <= SMBRA_M_START;
                  end
                end
              end
            end
          endcase
        end
        // R5 R6 stop: data low then high with clock high
        SMBRA_M_STOP: if (tick) begin
          ph <= ph + 2'h1;
          unique case (ph)
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            2'h3: st <= SMBRA_M_DONE;
          endcase
        end
        SMBRA_M_DONE: begin
          busy <= 1'b0; done <= 1'b1; st <= SMBRA_M_IDLE;
        end
        default: st <= SMBRA_M_IDLE;
      endcase
    end
  end

  // open drain: only low is driven
  assign bus.clk_o    = 1'b0;
  assign bus.clk_oe   = ~scl_q;
  assign bus.dat_m_o  = 1'b0;
  assign bus.dat_m_oe = ~sda_q;
endmodule
`default_nettype wire

// ==== verification/smbra_checker.sv ====
// wire-level checker for the register access link
`default_nettype none
module smbra_checker
  import smbra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link pins and resolved levels
  input wire logic clk_o,
  input wire logic clk_oe,
  input wire logic dat_m_o,
  input wire logic dat_m_oe,
  input wire logic dat_s_o,
  input wire logic dat_s_oe,
  input wire logic bus_clk,
  input wire logic bus_dat
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // bit and byte tracking, restarted by every start
  logic       clk_q;
  logic       dat_q;
  logic       rd;
  logic [3:0] bitn;
  logic [1:0] nbyte;
  logic [7:0] sh;
  wire        rise   = bus_clk & ~clk_q;
  wire        start  = bus_clk & clk_q & dat_q & ~bus_dat;
  wire        stop   = bus_clk & clk_q & ~dat_q & bus_dat;
  wire        ninth  = rise & (bitn == 4'h8);
  wire        s_pull = dat_s_oe & ~dat_s_o;
  wire        m_pull = dat_m_oe & ~dat_m_o;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {clk_q, dat_q, rd, bitn, nbyte, sh} <= {2'h3, 15'h0000};
    end else begin
      clk_q <= bus_clk;
      dat_q <= bus_dat;
      if (start) begin
        {rd, bitn, nbyte} <= 7'h00;
      end else if (ninth) begin
        bitn  <= 4'h0;
        nbyte <= nbyte + 2'(nbyte != 2'h3);
        if (nbyte == 2'h0) rd <= sh[0];
      end else if (rise) begin
        bitn <= bitn + 4'h1;
        sh   <= {sh[6:0], bus_dat};
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // properties
  property p_addr_ack;
    ninth && nbyte == 2'h0 && sh[7:1] == SMBRA_DEV_ADDR |-> !bus_dat;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_wr_ack;
    ninth && !rd && (nbyte == 2'h1 || nbyte == 2'h2) |-> !bus_dat;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  property p_nack_free;
    ninth && rd && nbyte == 2'h1 |-> !s_pull && bus_dat;
  endproperty
  a_nack_free: assert property (p_nack_free)
    else $error("read byte not closed by a released nack");
  property p_stable;
    bus_clk && clk_q |-> $stable(dat_s_oe);
  endproperty
  a_stable: assert property (p_stable)
    else $error("slave data moved while clock high");
  // the stop's tenth pulse counts as one rise of a new frame
  property p_frame;
    stop |-> bitn == 4'h1 && nbyte != 2'h0;
  endproperty
  a_frame: assert property (p_frame)
    else $error("stop inside a byte frame");
  property p_start_free;
    start |-> !s_pull;
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("slave pulls data at start");
  property p_rd_master_free;
    rise && rd && nbyte == 2'h1 && bitn != 4'h8 |-> !m_pull;
  endproperty
  a_rd_master_free: assert property (p_rd_master_free)
    else $error("master pulls data in read byte");
  property p_wr_slave_free;
    rise && !rd && bitn != 4'h8 |-> !s_pull;
  endproperty
  a_wr_slave_free: assert property (p_wr_slave_free)
    else $error("slave pulls data in master bits");
  property p_clk_owner;
    !bus_clk |-> clk_oe && !clk_o;
  endproperty
  a_clk_owner: assert property (p_clk_owner)
    else $error("link clock low without the master pulling it");
  c_rd: cover property (ninth && rd && nbyte == 2'h1);
  c_sr: cover property (start && nbyte != 2'h0);
  c_wr: cover property (ninth && !rd && nbyte == 2'h2);
endmodule
`default_nettype wire

// ==== verification/smbra_tb.sv ====
// bench for the register access link, both ends face to face
`default_nettype none
module smbus_register_access_slave_tb
  import smbra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and observation
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       req = 1'b0;
  logic       to_dis = 1'b0;
  smbra_cmd_t cmd = SMBRA_CMD_SEND;
  logic [7:0] code = 8'h00;
  logic [7:0] wd = 8'h00;
  logic       busy, done, ack_err, wr, wr_b, a;
  logic [7:0] rdata, ptr, wdat, ptr_b, wdat_b;
  logic [7:0] regs [256] = '{default: 8'h00};
  logic [7:0] wk [3] = '{8'h00, 8'hff, 8'h7e};
  logic [7:0] wv [3] = '{8'h3c, 8'hc3, 8'h81};
  // pull flags of the hand-driven second link
  logic       b_clk_pull = 1'b0;
  logic       b_dat_pull = 1'b0;
  int         err_total = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         n_wr = 0;
  int         n_wr_b = 0;
  always #2 clk = ~clk;
  smbra_if bus_a ();
  smbra_if bus_b ();
  assign bus_b.clk_o    = 1'b0;
  assign bus_b.clk_oe   = b_clk_pull;
  assign bus_b.dat_m_o  = 1'b0;
  assign bus_b.dat_m_oe = b_dat_pull;
  smbra_master smbra_master_inst (.clk(clk), .reset_n(reset_n),
    .bus(bus_a.master), .req(req), .cmd(cmd), .cmd_code(code),
    .wdata(wd), .busy(busy), .done(done), .ack_err(ack_err),
    .rdata(rdata));
  smbra_slave #(.TIMEOUT_CYC(2000)) smbra_slave_inst (.clk(clk),
    .reset_n(reset_n), .bus(bus_a.slave), .timeout_dis(to_dis),
    .pointer(ptr), .reg_wr(wr), .reg_wdata(wdat),
    .reg_rdata(regs[ptr]));
  // second slave only sees the hand-driven link, so its data is idle
  smbra_slave #(.TIMEOUT_CYC(2000)) smbra_slave_inst2 (.clk(clk),
    .reset_n(reset_n), .bus(bus_b.slave), .timeout_dis(to_dis),
    .pointer(ptr_b), .reg_wr(wr_b), .reg_wdata(wdat_b),
    .reg_rdata(8'h00));
  smbra_checker smbra_checker_inst (.clk(clk), .reset_n(reset_n),
    .clk_o(bus_a.clk_o), .clk_oe(bus_a.clk_oe),
    .dat_m_o(bus_a.dat_m_o), .dat_m_oe(bus_a.dat_m_oe),
    .dat_s_o(bus_a.dat_s_o), .dat_s_oe(bus_a.dat_s_oe),
    .bus_clk(bus_a.bus_clk), .bus_dat(bus_a.bus_dat));
  // register file model and run limit
  always @(posedge clk) begin
    cyc++;
    if (wr) begin
      regs[ptr] <= wdat;
      n_wr++;
    end
    if (wr_b) n_wr_b++;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  // ==========================================================
  // tasks
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic run(input smbra_cmd_t c, input logic [7:0] k, w);
    int n;
    while (busy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    cmd = c;
    code = k;
    wd = w;
    req = 1'b1;
    @(posedge clk);
    #1 req = 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(8'(done), 8'h01);
  endtask
  // one 64 ns bit on the second link, clock left high
  task automatic bb(input logic v, output logic s);
    b_clk_pull = 1'b1;
    #16 b_dat_pull = ~v;
    #16 b_clk_pull = 1'b0;
    #16 s = bus_b.bus_dat;
    #16;
  endtask
  task automatic bbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bb(v[i], s);
    bb(1'b1, ack);
  endtask
  task automatic bstop();
    b_clk_pull = 1'b1;
    #16 b_dat_pull = 1'b1;
    #16 b_clk_pull = 1'b0;
    #16 b_dat_pull = 1'b0;
    #16;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      run(SMBRA_CMD_WRITE, wk[i], wv[i]);
      chk(8'(ack_err), 8'h00);
      chk(ptr, wk[i]);
      chk(regs[wk[i]], wv[i]);
    end
    run(SMBRA_CMD_SEND, 8'hff, 8'h55);
    chk(ptr, 8'hff);
    chk(8'(n_wr), 8'h03);
    run(SMBRA_CMD_RECV, 8'h00, 8'h00);
    chk(rdata, 8'hc3);
    chk(ptr, 8'hff);
    run(SMBRA_CMD_RDBYTE, 8'h00, 8'h55);
    chk(rdata, 8'h3c);
    chk(ptr, 8'h00);
    chk(8'(n_wr), 8'h03);
    chk(8'(ack_err), 8'h00);
    // foreign address: no ack, rest of transfer ignored
    b_dat_pull = 1'b1;
    #16;
    bbyte(8'h5e, a);
    chk(8'(a), 8'h01);
    bbyte(8'h11, a);
    chk(8'(a), 8'h01);
    bstop();
    chk(8'(n_wr_b), 8'h00);
    chk(ptr_b, 8'h00);
    // stalled clock while acked: held when disabled, released when not
    @(posedge clk);
    #1 to_dis = 1'b1;
    b_dat_pull = 1'b1;
    #16;
    bbyte(8'h5c, a);
    chk(8'(a), 8'h00);
    repeat (2200) @(posedge clk);
    #1 chk(8'(bus_b.bus_dat), 8'h00);
    to_dis = 1'b0;
    repeat (2200) @(posedge clk);
    #1 chk(8'(bus_b.bus_dat), 8'h01);
    bstop();
    summarize();
  end
endmodule
`default_nettype wire
